// file: rtl/qrt_pkg.sv
package qrt_pkg;
    // ----------------------------------------
    // sizes and reset values
    // ----------------------------------------
    localparam int NUM_CH = 4;
    localparam int SYNC_STAGES = 2;
    localparam logic [NUM_CH-1:0] DATA_RST = 4'h0;
    localparam logic PIN_RST = 1'h0;

    // ----------------------------------------
    // states
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_OFF  = 4'h1,
        ST_THRU = 4'h2,
        ST_WAIT = 4'h4,
        ST_SYNC = 4'h8
    } qrt_state_t;
endpackage : qrt_pkg

// file: rtl/qrt_sync.sv
`timescale 1ns/1ns
module qrt_sync #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // levels
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    // ----------------------------------------
    // two-stage synchroniser
    // ----------------------------------------
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_pinOut;

    always_comb begin
        if (!rstn) begin
            next_stage1 = '0;
            next_pinOut = '0;
        end else begin
            next_stage1 = pinIn;
            next_pinOut = stage1;
        end
    end

    always_ff @(posedge clk) begin
        stage1 <= next_stage1;
        pinOut <= next_pinOut;
    end
endmodule : qrt_sync

// file: rtl/qrt_retimer.sv
// Operation
// - four channels, each input to own output, sharing select, clock, enable
// - select high: each output follows its own input, no clocking
// - select high: capture clock activity is ignored
// - select low: all inputs captured together on capture clock rising edge, except an edge in the first cycle after enabling
// - enable high: outputs active and show selected mode's data; with select low, outputs stay low until the first capture after enabling
// - enable low: every output driven low
// - while disabled, clock, select and data changes are disregarded
`timescale 1ns/1ns
module qrt_retimer #(
    parameter int NUM_CH = qrt_pkg::NUM_CH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control pins
    input wire logic enPin,
    input wire logic selPin,
    input wire logic capClk,
    // channel data
    input wire logic [NUM_CH-1:0] dataIn,
    output logic [NUM_CH-1:0] dataOut
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [NUM_CH+2:0] pinSync;
    logic enS;
    logic selS;
    logic capClkS;
    logic [NUM_CH-1:0] dataS;

    qrt_sync #(
        .WIDTH(NUM_CH + 3)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .pinIn({enPin, selPin, capClk, dataIn}),
        .pinOut(pinSync)
    );

    assign {enS, selS, capClkS, dataS} = pinSync;

    // ----------------------------------------
    // state and capture
    // ----------------------------------------
    qrt_pkg::qrt_state_t state;
    qrt_pkg::qrt_state_t next_state;
    logic capClkPrev;
    logic next_capClkPrev;
    logic [NUM_CH-1:0] held;
    logic [NUM_CH-1:0] next_held;
    logic [NUM_CH-1:0] next_dataOut;
    logic rise;

    assign rise = capClkS & ~capClkPrev;

    always_comb begin
        next_state = state;
        next_held = held;
        next_dataOut = '0;
        next_capClkPrev = capClkS;
        if (!rstn) begin
            next_state = qrt_pkg::ST_OFF;
            next_held = qrt_pkg::DATA_RST;
            next_capClkPrev = qrt_pkg::PIN_RST;
        end else if (!enS) begin
            next_state = qrt_pkg::ST_OFF;
        end else if (selS) begin
            next_state = qrt_pkg::ST_THRU;
            next_held = dataS;
            next_dataOut = dataS;
        end else begin
            case (state)
                qrt_pkg::ST_OFF: begin
                    next_state = qrt_pkg::ST_WAIT;
                end
                qrt_pkg::ST_WAIT: begin
                    if (rise) begin
                        next_state = qrt_pkg::ST_SYNC;
                        next_held = dataS;
                        next_dataOut = dataS;
                    end
                end
                qrt_pkg::ST_THRU, qrt_pkg::ST_SYNC: begin
                    next_state = qrt_pkg::ST_SYNC;
                    if (rise) begin
                        next_held = dataS;
                        next_dataOut = dataS;
                    end else begin
                        next_dataOut = held;
                    end
                end
                default: begin
                    next_state = qrt_pkg::ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        state <= next_state;
        held <= next_held;
        dataOut <= next_dataOut;
        capClkPrev <= next_capClkPrev;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence thruSteady;
        enS && selS ##1 enS && selS && dataS == $past(dataS);
    endsequence

    sequence reEnableClocked;
        state == qrt_pkg::ST_OFF && enS && !selS;
    endsequence

    sequence waitClocked;
        state == qrt_pkg::ST_WAIT && enS && !selS;
    endsequence

    sequence syncClocked;
        state == qrt_pkg::ST_SYNC && enS && !selS;
    endsequence

    sequence clockedRun;
        (state == qrt_pkg::ST_THRU || state == qrt_pkg::ST_SYNC) && enS && !selS;
    endsequence

    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
            chan_follow_a: assert property (@(posedge clk) disable iff (!rstn)
                enS && selS |=> dataOut[i] == $past(dataS[i]))
                else $error("channel output does not follow its input");
            chan_capture_a: assert property (@(posedge clk) disable iff (!rstn)
                enS && !selS && rise && state != qrt_pkg::ST_OFF |=> dataOut[i] == $past(dataS[i]))
                else $error("channel missed clocked capture");
            chan_low_a: assert property (@(posedge clk) disable iff (!rstn)
                !enS |=> !dataOut[i])
                else $error("disabled channel output not low");
        end
    endgenerate

    thru_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        enS && selS |=> dataOut == $past(dataS))
        else $error("pass-through output wrong");

    clock_ignored_a: assert property (@(posedge clk) disable iff (!rstn)
        thruSteady |=> $stable(dataOut))
        else $error("output moved in pass-through with steady input");

    sync_capture_a: assert property (@(posedge clk) disable iff (!rstn)
        enS && !selS && rise && state != qrt_pkg::ST_OFF |=> dataOut == $past(dataS))
        else $error("clocked capture missed");

    sync_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        state == qrt_pkg::ST_SYNC && enS && !selS && !rise |=> $stable(dataOut))
        else $error("clocked output changed without edge");

    enabled_data_a: assert property (@(posedge clk) disable iff (!rstn)
        enS && selS && dataS != '0 |=> dataOut != '0)
        else $error("enabled output stuck low");

    disabled_low_a: assert property (@(posedge clk) disable iff (!rstn)
        !enS |=> dataOut == '0 && state == qrt_pkg::ST_OFF)
        else $error("disabled output not low");

    frozen_held_a: assert property (@(posedge clk) disable iff (!rstn)
        !enS ##1 !enS |=> $stable(held))
        else $error("capture changed while disabled");

    reenable_wait_a: assert property (@(posedge clk) disable iff (!rstn)
        reEnableClocked |=> dataOut == '0 && state == qrt_pkg::ST_WAIT)
        else $error("re-enable showed stale data");

    thru_state_a: assert property (@(posedge clk) disable iff (!rstn)
        enS && selS |=> state == qrt_pkg::ST_THRU)
        else $error("pass-through mode not entered");

    held_track_a: assert property (@(posedge clk) disable iff (!rstn)
        enS && selS |=> held == $past(dataS))
        else $error("pass-through did not track input");

    clocked_state_a: assert property (@(posedge clk) disable iff (!rstn)
        clockedRun |=> state == qrt_pkg::ST_SYNC)
        else $error("clocked mode not entered");

    mode_switch_a: assert property (@(posedge clk) disable iff (!rstn)
        state == qrt_pkg::ST_THRU && enS && !selS && !rise |=> $stable(dataOut))
        else $error("mode switch changed output without edge");

    sync_output_a: assert property (@(posedge clk) disable iff (!rstn)
        syncClocked |=> dataOut == held)
        else $error("clocked output differs from captured data");

    wait_empty_a: assert property (@(posedge clk) disable iff (!rstn)
        waitClocked ##0 !rise |=> dataOut == '0 && state == qrt_pkg::ST_WAIT)
        else $error("output shown before first capture");

    wait_first_a: assert property (@(posedge clk) disable iff (!rstn)
        waitClocked ##0 rise |=> dataOut == $past(dataS) && state == qrt_pkg::ST_SYNC)
        else $error("first capture after re-enable missed");

    off_thru_a: assert property (@(posedge clk) disable iff (!rstn)
        state == qrt_pkg::ST_OFF && enS && selS |=> state == qrt_pkg::ST_THRU && dataOut == $past(dataS))
        else $error("re-enable into pass-through wrong");

    off_clock_a: assert property (@(posedge clk) disable iff (!rstn)
        !enS && rise |=> dataOut == '0 && $stable(held))
        else $error("clock edge acted while disabled");

    sel_ignored_a: assert property (@(posedge clk) disable iff (!rstn)
        !enS && $changed(selS) |=> dataOut == '0 && state == qrt_pkg::ST_OFF)
        else $error("select change acted while disabled");

    edge_track_a: assert property (@(posedge clk) disable iff (!rstn)
        !enS |=> capClkPrev == $past(capClkS))
        else $error("clock edge tracking stopped while disabled");

    rise_once_a: assert property (@(posedge clk) disable iff (!rstn)
        rise |=> !rise)
        else $error("one clock edge seen twice");
endmodule : qrt_retimer

// file: tb/qrt_src.sv
`timescale 1ns/1ns
module qrt_src (
    // clock
    input wire logic clk,
    // request
    input wire logic go,
    input wire logic swap,
    input wire logic [3:0] val,
    // pins
    output logic capClk,
    output logic [3:0] dataIn
);
    int cnt;
    // new data, then the true clock high for 4 cycles; swap feeds the complement line instead
    initial begin
        cnt = 0;
        capClk = 1'h0;
        dataIn = 4'h0;
        forever begin
            @(posedge clk);
            if (go) begin
                dataIn <= val;
                cnt <= 1;
            end else if (cnt != 0) begin
                cnt <= (cnt == 8) ? 0 : cnt + 1;
            end
            capClk <= swap ^ (cnt >= 3 && cnt < 7);
        end
    end
endmodule : qrt_src

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk, rstn, enPin, selPin, go, swap, capClk;
    logic [3:0] val, dataIn, dataOut;
    int fails = 0;
    int n_compared = 0;
    qrt_retimer u_qrt_retimer (.clk(clk), .rstn(rstn), .enPin(enPin), .selPin(selPin),
        .capClk(capClk), .dataIn(dataIn), .dataOut(dataOut));
    qrt_src u_qrt_src (.clk(clk), .go(go), .swap(swap), .val(val), .capClk(capClk), .dataIn(dataIn));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic results;
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    task automatic check(input logic [3:0] exp);
        @(negedge clk);
        n_compared++;
        if (dataOut !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, dataOut, exp);
        end
        @(posedge clk);
    endtask : check
    task automatic await(input logic [3:0] exp);
        int i;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (i < 12 && dataOut !== exp);
        n_compared++;
        if (dataOut === exp) begin
            @(posedge clk);
        end else begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, dataOut, exp);
            results();
        end
    endtask : await
    task automatic send(input logic [3:0] v);
        val <= v;
        go <= 1'h1;
        tick(1);
        go <= 1'h0;
    endtask : send
    task automatic thru_mode;
        selPin <= 1'h1;
        enPin <= 1'h1;
        send(4'h5);
        await(4'h5);
        tick(8);
        check(4'h5);
    endtask : thru_mode
    task automatic clocked_mode;
        selPin <= 1'h0;
        tick(5);
        send(4'ha);
        tick(3);
        check(4'h5);
        await(4'ha);
    endtask : clocked_mode
    task automatic disable_all;
        enPin <= 1'h0;
        tick(5);
        check(4'h0);
        selPin <= 1'h1;
        send(4'hf);
        tick(9);
        check(4'h0);
    endtask : disable_all
    task automatic reenable;
        selPin <= 1'h0;
        tick(4);
        enPin <= 1'h1;
        tick(6);
        check(4'h0);
        send(4'h3);
        await(4'h3);
    endtask : reenable
    task automatic swap_mode;
        selPin <= 1'h1;
        swap <= 1'h1;
        tick(6);
        check(4'h3);
        selPin <= 1'h0;
        tick(5);
        send(4'hc);
        tick(7);
        check(4'h3);
        await(4'hc);
    endtask : swap_mode
    task automatic thru_reenable;
        enPin <= 1'h0;
        selPin <= 1'h1;
        tick(5);
        check(4'h0);
        enPin <= 1'h1;
        await(4'hc);
    endtask : thru_reenable
    initial begin
        rstn = 1'h0;
        enPin = 1'h0;
        selPin = 1'h0;
        go = 1'h0;
        swap = 1'h0;
        val = 4'h0;
        tick(5);
        rstn <= 1'h1;
        tick(2);
        thru_mode();
        clocked_mode();
        disable_all();
        reenable();
        swap_mode();
        thru_reenable();
        results();
    end
endmodule : tb
